//--- shared/rfic_pkg.sv
// Package: constants and types for the reset flag and init control block
package rfic_pkg;
	// Reset source kinds, in priority order
	typedef enum logic [2:0] {
		RFIC_SRC_NONE,
		RFIC_SRC_POR,
		RFIC_SRC_LV,
		RFIC_SRC_PIN,
		RFIC_SRC_WDT_RUN,
		RFIC_SRC_WDT_HALT
	} rfic_src_e;

	// Widths
	localparam int RFIC_PC_W     = 11;
	localparam int RFIC_SP_W     = 3;
	localparam int RFIC_PORT_W   = 8;
	localparam int RFIC_INT_W    = 8;
	localparam int RFIC_TMR_W    = 2;
	localparam int RFIC_WDT_W    = 16;
	localparam int RFIC_ADDR_W   = 4;
	localparam int RFIC_DATA_W   = 8;

	// Reset values
	localparam logic [RFIC_PC_W-1:0]   RFIC_PC_RST    = 11'h000;
	localparam logic [RFIC_SP_W-1:0]   RFIC_SP_CLR    = 3'h0;
	localparam logic [RFIC_SP_W-1:0]   RFIC_SP_TOP    = 3'h7;
	localparam logic [RFIC_PORT_W-1:0] RFIC_PORT_IN   = 8'hff;
	localparam logic [RFIC_INT_W-1:0]  RFIC_INT_OFF   = 8'h00;
	localparam logic [RFIC_TMR_W-1:0]  RFIC_TMR_OFF   = 2'h0;
	localparam logic [RFIC_WDT_W-1:0]  RFIC_WDT_CLR   = 16'h0000;
	localparam logic [RFIC_WDT_W-1:0]  RFIC_WDT_ONE   = 16'h0001;

	// Register offsets
	localparam logic [RFIC_ADDR_W-1:0] RFIC_OFS_FLAGS = 4'h0;
	localparam logic [RFIC_ADDR_W-1:0] RFIC_OFS_LVCLR = 4'h1;
	localparam logic [RFIC_ADDR_W-1:0] RFIC_OFS_IRQST = 4'h2;
	localparam logic [RFIC_ADDR_W-1:0] RFIC_OFS_IRQEN = 4'h3;
	localparam logic [RFIC_ADDR_W-1:0] RFIC_OFS_IRQCL = 4'h4;
	localparam logic [RFIC_ADDR_W-1:0] RFIC_OFS_SRC   = 4'h5;

	// Flag register field positions
	localparam int RFIC_BIT_TO  = 0;
	localparam int RFIC_BIT_PD  = 1;
	localparam int RFIC_BIT_LV  = 2;
	// Interrupt status field positions
	localparam int RFIC_IRQ_W   = 3;
	localparam int RFIC_IRQ_WDT = 0;
	localparam int RFIC_IRQ_LV  = 1;
	localparam int RFIC_IRQ_PIN = 2;
	localparam logic [RFIC_IRQ_W-1:0] RFIC_IRQ_CLR = 3'h0;
endpackage

//--- design/rfic_sync.sv
// Two-flop synchroniser with async reset to a constant level
`timescale 1ns/1ps
module rfic_sync #(
	parameter logic RST_VAL = 1'b0	// Level held during reset
) (
	input  wire logic ref_clk_i,	// System clock
	input  wire logic rst_i,	// Async reset, active high
	input  wire logic d_i,	// Asynchronous level in
	output logic      q_o	// Synchronised level out
);
	logic meta_r;	// First stage, read only by second stage
	logic q_r;	// Second stage

	// Shift chain; only q_r is visible outside
	always_ff @(posedge ref_clk_i or posedge rst_i) begin
		if (rst_i) begin
			meta_r <= RST_VAL;
			q_r    <= RST_VAL;
		end else begin
			meta_r <= d_i;
			q_r    <= meta_r;
		end
	end

	assign q_o = q_r;
endmodule

//--- design/rfic_top.sv
// Reset flag and init control: reset source capture, flags, init values
`timescale 1ns/1ps
module rfic_top
	import rfic_pkg::*;
#(
	parameter int PC_W = RFIC_PC_W	// Program counter width
) (
	input  wire logic                   ref_clk_i,	// 20 MHz system clock
	input  wire logic                   rst_i,	// Power-on reset, async, high
	input  wire logic                   lv_event_i,	// Low-voltage reset event, async
	input  wire logic                   pin_rst_n_i,	// External reset pin, low active
	input  wire logic                   wdt_timeout_i,	// Watchdog overflow, same clock
	input  wire logic                   halt_enter_i,	// Halt instruction, one-cycle pulse
	input  wire logic                   wake_i,	// Wake-up from halt, one-cycle pulse
	input  wire logic                   clr_wdt_i,	// Software watchdog clear pulse
	input  wire logic [RFIC_ADDR_W-1:0] addr_i,	// Register address
	input  wire logic [RFIC_DATA_W-1:0] wdata_i,	// Register write data
	input  wire logic                   wr_i,	// Write strobe
	input  wire logic                   rd_i,	// Read strobe
	output logic      [RFIC_DATA_W-1:0] rdata_o,	// Read data, cycle after rd_i
	output logic                        timeout_flag_o,	// Time-out flag
	output logic                        powerdown_flag_o,	// Power-down flag
	output logic                        lv_flag_o,	// Low-voltage reset flag
	output logic                        sys_rst_o,	// Merged internal reset
	output logic                        halted_o,	// Halt state
	output logic      [PC_W-1:0]        pc_load_o,	// Program counter load value
	output logic                        pc_load_en_o,	// Program counter load pulse
	output logic      [RFIC_SP_W-1:0]   sp_o,	// Stack pointer init value
	output logic                        sp_load_o,	// Stack pointer load pulse
	output logic      [RFIC_INT_W-1:0]  int_en_o,	// Interrupt enable init
	output logic      [RFIC_TMR_W-1:0]  tmr_on_o,	// Timer on bits
	output logic      [RFIC_PORT_W-1:0] port_dir_o,	// Port direction, 1 is input
	output logic                        regs_init_o,	// Load defaults pulse
	output logic      [RFIC_WDT_W-1:0]  wdt_cnt_o,	// Watchdog counter
	output logic                        irq_o	// Level interrupt
);
	////////////////////////////////////////////////////////////////////
	// Input synchronisation
	logic lv_s;	// Synchronised low-voltage event
	logic pin_n_s;	// Synchronised reset pin level

	rfic_sync #(.RST_VAL(1'b0)) u_lv_sync (
		.ref_clk_i (ref_clk_i),
		.rst_i     (rst_i),
		.d_i       (lv_event_i),
		.q_o       (lv_s)
	);

	rfic_sync #(.RST_VAL(1'b1)) u_pin_sync (
		.ref_clk_i (ref_clk_i),
		.rst_i     (rst_i),
		.d_i       (pin_rst_n_i),
		.q_o       (pin_n_s)
	);

	////////////////////////////////////////////////////////////////////
	// Source selection
	logic      halted_r;	// In sleep or idle
	logic      hold_r;	// Internal reset asserted
	logic      por_pend_r;	// Power-on release pending
	rfic_src_e src_r;	// Last reset source
	rfic_src_e src_nxt;	// Source seen this cycle
	logic      evt_go;	// A reset source fires now

	// Low-voltage detect is disabled in halt, so only seen while running
	always_comb begin
		src_nxt = RFIC_SRC_NONE;
		if (lv_s && !halted_r) begin
			src_nxt = RFIC_SRC_LV;
		end else if (!pin_n_s) begin
			src_nxt = RFIC_SRC_PIN;
		end else if (wdt_timeout_i && halted_r) begin
			src_nxt = RFIC_SRC_WDT_HALT;
		end else if (wdt_timeout_i) begin
			src_nxt = RFIC_SRC_WDT_RUN;
		end
	end

	assign evt_go = (src_nxt != RFIC_SRC_NONE);

	////////////////////////////////////////////////////////////////////
	// Merged reset: held while a level source stays active
	always_ff @(posedge ref_clk_i or posedge rst_i) begin
		if (rst_i) begin
			hold_r     <= 1'b1;
			por_pend_r <= 1'b1;
			src_r      <= RFIC_SRC_POR;
		end else begin
			por_pend_r <= 1'b0;
			hold_r     <= evt_go;
			if (evt_go) begin
				src_r <= src_nxt;
			end
		end
	end

	assign sys_rst_o = hold_r;

	////////////////////////////////////////////////////////////////////
	// Release pulse: first cycle with no source after a hold
	logic rel;	// Release edge of the merged reset
	assign rel = hold_r && !evt_go;

	////////////////////////////////////////////////////////////////////
	// Halt state
	always_ff @(posedge ref_clk_i or posedge rst_i) begin
		if (rst_i) begin
			halted_r <= 1'b0;
		end else if (evt_go || wake_i) begin
			halted_r <= 1'b0;
		end else if (halt_enter_i) begin
			halted_r <= 1'b1;
		end
	end

	assign halted_o = halted_r;

	////////////////////////////////////////////////////////////////////
	// Time-out and power-down flags in the status register
	logic to_r;	// Time-out flag
	logic pd_r;	// Power-down flag

	always_ff @(posedge ref_clk_i or posedge rst_i) begin
		if (rst_i) begin
			to_r <= 1'b0;
			pd_r <= 1'b0;
		end else begin
			unique case (src_nxt)
				RFIC_SRC_WDT_HALT: begin
					to_r <= 1'b1;
					pd_r <= 1'b1;
				end
				RFIC_SRC_WDT_RUN: begin
					to_r <= 1'b1;
				end
				RFIC_SRC_LV, RFIC_SRC_PIN: begin
					// Flags untouched
				end
				RFIC_SRC_NONE: begin
					if (halt_enter_i) begin
						to_r <= 1'b0;
						pd_r <= 1'b1;
					end else if (clr_wdt_i) begin
						to_r <= 1'b0;
						pd_r <= 1'b0;
					end
				end
				default: begin
				end
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////
	// Sticky low-voltage reset flag; set wins over software clear
	logic lv_r;	// Low-voltage reset flag
	logic lv_clr;	// Software clear strobe

	assign lv_clr = wr_i && (addr_i == RFIC_OFS_LVCLR) && wdata_i[RFIC_BIT_LV];

	always_ff @(posedge ref_clk_i or posedge rst_i) begin
		if (rst_i) begin
			lv_r <= 1'b0;
		end else if (src_nxt == RFIC_SRC_LV) begin
			lv_r <= 1'b1;
		end else if (lv_clr) begin
			lv_r <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////
	// Init outputs, produced at the release edge
	logic warm;	// Release follows a halt watchdog reset
	assign warm = (src_r == RFIC_SRC_WDT_HALT);

	always_ff @(posedge ref_clk_i or posedge rst_i) begin
		if (rst_i) begin
			pc_load_o    <= PC_W'(RFIC_PC_RST);
			pc_load_en_o <= 1'b0;
			sp_o         <= RFIC_SP_TOP;
			sp_load_o    <= 1'b0;
			regs_init_o  <= 1'b0;
			int_en_o     <= RFIC_INT_OFF;
			tmr_on_o     <= RFIC_TMR_OFF;
			port_dir_o   <= RFIC_PORT_IN;
		end else begin
			pc_load_en_o <= rel;
			sp_load_o    <= rel;
			regs_init_o  <= rel && !warm;
			if (rel) begin
				pc_load_o <= PC_W'(RFIC_PC_RST);
				// Warm reset clears SP; others point to top
				sp_o      <= warm ? RFIC_SP_CLR : RFIC_SP_TOP;
			end
			if (rel && !warm) begin
				int_en_o   <= RFIC_INT_OFF;
				tmr_on_o   <= RFIC_TMR_OFF;
				port_dir_o <= RFIC_PORT_IN;
			end
		end
	end

	////////////////////////////////////////////////////////////////////
	// Watchdog counter: cleared in reset, counts from release
	always_ff @(posedge ref_clk_i or posedge rst_i) begin
		if (rst_i) begin
			wdt_cnt_o <= RFIC_WDT_CLR;
		end else if (hold_r || clr_wdt_i || por_pend_r) begin
			wdt_cnt_o <= RFIC_WDT_CLR;
		end else begin
			wdt_cnt_o <= wdt_cnt_o + RFIC_WDT_ONE;
		end
	end

	////////////////////////////////////////////////////////////////////
	// Interrupt status, enable and clear
	logic [RFIC_IRQ_W-1:0] irq_st_r;	// Sticky events
	logic [RFIC_IRQ_W-1:0] irq_en_r;	// Enable mask
	logic [RFIC_IRQ_W-1:0] irq_set;	// Event pulses
	logic [RFIC_IRQ_W-1:0] irq_clr;	// Clear strobes

	always_comb begin
		irq_set               = RFIC_IRQ_CLR;
		irq_set[RFIC_IRQ_WDT] = (src_nxt == RFIC_SRC_WDT_RUN) || (src_nxt == RFIC_SRC_WDT_HALT);
		irq_set[RFIC_IRQ_LV]  = (src_nxt == RFIC_SRC_LV);
		irq_set[RFIC_IRQ_PIN] = (src_nxt == RFIC_SRC_PIN);
		irq_clr = RFIC_IRQ_CLR;
		if (wr_i && (addr_i == RFIC_OFS_IRQCL)) begin
			irq_clr = wdata_i[RFIC_IRQ_W-1:0];
		end
	end

	// Set wins over clear so no event is lost
	always_ff @(posedge ref_clk_i or posedge rst_i) begin
		if (rst_i) begin
			irq_st_r <= RFIC_IRQ_CLR;
		end else begin
			irq_st_r <= (irq_st_r & ~irq_clr) | irq_set;
		end
	end

	// Enable register survives internal resets; only power-on clears it
	always_ff @(posedge ref_clk_i or posedge rst_i) begin
		if (rst_i) begin
			irq_en_r <= RFIC_IRQ_CLR;
		end else if (wr_i && (addr_i == RFIC_OFS_IRQEN)) begin
			irq_en_r <= wdata_i[RFIC_IRQ_W-1:0];
		end
	end

	always_ff @(posedge ref_clk_i or posedge rst_i) begin
		if (rst_i) begin
			irq_o <= 1'b0;
		end else begin
			irq_o <= |(((irq_st_r & ~irq_clr) | irq_set) & irq_en_r);
		end
	end

	////////////////////////////////////////////////////////////////////
	// Flag outputs and read port
	always_ff @(posedge ref_clk_i or posedge rst_i) begin
		if (rst_i) begin
			timeout_flag_o   <= 1'b0;
			powerdown_flag_o <= 1'b0;
			lv_flag_o        <= 1'b0;
		end else begin
			timeout_flag_o   <= to_r;
			powerdown_flag_o <= pd_r;
			lv_flag_o        <= lv_r;
		end
	end

	// Unmapped and write-only offsets read as zero
	always_ff @(posedge ref_clk_i or posedge rst_i) begin
		if (rst_i) begin
			rdata_o <= '0;
		end else begin
			rdata_o <= '0;
			if (rd_i) begin
				unique case (addr_i)
					RFIC_OFS_FLAGS: begin
						rdata_o[RFIC_BIT_TO] <= to_r;
						rdata_o[RFIC_BIT_PD] <= pd_r;
						rdata_o[RFIC_BIT_LV] <= lv_r;
					end
					RFIC_OFS_IRQST: rdata_o[RFIC_IRQ_W-1:0] <= irq_st_r;
					RFIC_OFS_IRQEN: rdata_o[RFIC_IRQ_W-1:0] <= irq_en_r;
					RFIC_OFS_SRC:   rdata_o[$bits(src_r)-1:0] <= src_r;
					default: begin
					end
				endcase
			end
		end
	end
endmodule

//--- dv/rfic_top_assertions.sv
// Checker: concurrent assertions on the reset flag block ports
`timescale 1ns/1ps
module rfic_top_chk
	import rfic_pkg::*;
#(
	parameter int PC_W = RFIC_PC_W	// Program counter width
) (
	input wire logic                   ref_clk_i,	// Clock
	input wire logic                   rst_i,	// Power-on reset
	input wire logic                   lv_event_i,	// Low-voltage event
	input wire logic                   wdt_timeout_i,	// Watchdog overflow
	input wire logic                   halt_enter_i,	// Halt pulse
	input wire logic                   timeout_flag_o,	// Time-out flag
	input wire logic                   powerdown_flag_o,	// Power-down flag
	input wire logic                   lv_flag_o,	// Low-voltage flag
	input wire logic                   sys_rst_o,	// Merged reset
	input wire logic                   halted_o,	// Halt state
	input wire logic [PC_W-1:0]        pc_load_o,	// PC load value
	input wire logic                   pc_load_en_o,	// PC load pulse
	input wire logic [RFIC_SP_W-1:0]   sp_o,	// SP value
	input wire logic                   sp_load_o,	// SP load pulse
	input wire logic                   regs_init_o,	// Defaults pulse
	input wire logic [RFIC_INT_W-1:0]  int_en_o,	// Int enables
	input wire logic [RFIC_PORT_W-1:0] port_dir_o,	// Port direction
	input wire logic [RFIC_WDT_W-1:0]  wdt_cnt_o	// Watchdog count
);
	// One domain, so clock and reset are given once
	default clocking cb @(posedge ref_clk_i); endclocking
	default disable iff (rst_i);

	////////////////////////////////////////////////////////////////////////
	// First edge after power-on: reset values still visible
	property p_por_flags; $fell(rst_i) |-> !timeout_flag_o && !powerdown_flag_o; endproperty
	a_por_flags: assert property (p_por_flags) else $error("flags not clear");
	property p_por_int; $fell(rst_i) |-> int_en_o == RFIC_INT_OFF; endproperty
	a_por_int: assert property (p_por_int) else $error("int enabled");
	property p_por_port; $fell(rst_i) |-> port_dir_o == RFIC_PORT_IN; endproperty
	a_por_port: assert property (p_por_port) else $error("port not input");
	// Counter must leave zero soon after release
	property p_wdt_cnt; $fell(sys_rst_o) |-> ##[1:3] wdt_cnt_o != RFIC_WDT_CLR; endproperty
	a_wdt_cnt: assert property (p_wdt_cnt) else $error("wdt idle");

	////////////////////////////////////////////////////////////////////////
	// Init values
	property p_pc_zero; pc_load_en_o |-> pc_load_o == '0; endproperty
	a_pc_zero: assert property (p_pc_zero) else $error("pc not zero");
	property p_warm_sp; sp_load_o && !regs_init_o |-> sp_o == RFIC_SP_CLR; endproperty
	a_warm_sp: assert property (p_warm_sp) else $error("warm sp");
	property p_cold_sp; sp_load_o && regs_init_o |-> sp_o == RFIC_SP_TOP; endproperty
	a_cold_sp: assert property (p_cold_sp) else $error("cold sp");

	////////////////////////////////////////////////////////////////////////
	// Flag updates, outputs lag the cause by two registers, the low-voltage flag by four
	property p_halt_pd; halt_enter_i |-> ##[1:3] powerdown_flag_o && !timeout_flag_o; endproperty
	a_halt_pd: assert property (p_halt_pd) else $error("halt flags");
	property p_wdt_run; wdt_timeout_i && !halted_o |-> ##[1:4] timeout_flag_o; endproperty
	a_wdt_run: assert property (p_wdt_run) else $error("run wdt flag");
	property p_wdt_halt;
		wdt_timeout_i && halted_o |-> ##[1:4] timeout_flag_o && powerdown_flag_o;
	endproperty
	a_wdt_halt: assert property (p_wdt_halt) else $error("halt wdt flags");
	property p_lv_keep;
		$rose(lv_flag_o) |-> $stable(timeout_flag_o) && $stable(powerdown_flag_o);
	endproperty
	a_lv_keep: assert property (p_lv_keep) else $error("lv moved flags");
	property p_lv_set; lv_event_i && !halted_o |-> ##[1:6] lv_flag_o; endproperty
	a_lv_set: assert property (p_lv_set) else $error("lv flag unset");
endmodule

bind rfic_top rfic_top_chk #(.PC_W(PC_W)) i_chk (.ref_clk_i(ref_clk_i), .rst_i(rst_i),
	.lv_event_i(lv_event_i), .wdt_timeout_i(wdt_timeout_i), .halt_enter_i(halt_enter_i),
	.timeout_flag_o(timeout_flag_o), .powerdown_flag_o(powerdown_flag_o),
	.lv_flag_o(lv_flag_o), .sys_rst_o(sys_rst_o), .halted_o(halted_o),
	.pc_load_o(pc_load_o), .pc_load_en_o(pc_load_en_o), .sp_o(sp_o), .sp_load_o(sp_load_o),
	.regs_init_o(regs_init_o), .int_en_o(int_en_o), .port_dir_o(port_dir_o),
	.wdt_cnt_o(wdt_cnt_o));

//--- dv/rfic_top_tb_top.sv
// Testbench: self-checking reset source scenarios
`timescale 1ns/1ps
module rfic_top_tb_top;
	import rfic_pkg::*;
	logic                   ref_clk_i, rst_i, lv_event_i, pin_rst_n_i, wr_i, rd_i;	// Drives
	logic [3:0]             evt;	// Event pulses
	wire logic              wdt_timeout_i, halt_enter_i, wake_i, clr_wdt_i;	// Event nets
	logic [RFIC_ADDR_W-1:0] addr_i;	// Address
	logic [RFIC_DATA_W-1:0] wdata_i, rdata_o;	// Data
	logic                   to_q, pd_q, lv_q, srst_q, halt_q, pce_q, spl_q, ri_q, irq_q;	// Outs
	logic [RFIC_PC_W-1:0]   pc_q;	// PC load value
	logic [RFIC_SP_W-1:0]   sp_q;	// SP value
	logic [RFIC_INT_W-1:0]  int_q;	// Int enables
	logic [RFIC_TMR_W-1:0]  tmr_q;	// Timer bits
	logic [RFIC_PORT_W-1:0] dir_q;	// Port direction
	logic [RFIC_WDT_W-1:0]  wdt_q;	// Watchdog count
	int                     err_count, checks_done, cyc;	// Tallies

	assign {clr_wdt_i, wake_i, halt_enter_i, wdt_timeout_i} = evt;

	rfic_top i_dut (.ref_clk_i(ref_clk_i), .rst_i(rst_i), .lv_event_i(lv_event_i),
		.pin_rst_n_i(pin_rst_n_i), .wdt_timeout_i(wdt_timeout_i), .halt_enter_i(halt_enter_i),
		.wake_i(wake_i), .clr_wdt_i(clr_wdt_i), .addr_i(addr_i), .wdata_i(wdata_i),
		.wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .timeout_flag_o(to_q),
		.powerdown_flag_o(pd_q), .lv_flag_o(lv_q), .sys_rst_o(srst_q), .halted_o(halt_q),
		.pc_load_o(pc_q), .pc_load_en_o(pce_q), .sp_o(sp_q), .sp_load_o(spl_q),
		.int_en_o(int_q), .tmr_on_o(tmr_q), .port_dir_o(dir_q), .regs_init_o(ri_q),
		.wdt_cnt_o(wdt_q), .irq_o(irq_q));

	////////////////////////////////////////////////////////////////////////
	// 20 MHz clock
	initial begin
		ref_clk_i = 1'b0;
		forever #25 ref_clk_i = ~ref_clk_i;
	end

	// Cut a hang short; the full run needs under a hundred cycles
	always @(posedge ref_clk_i) begin
		cyc++;
		if (cyc == 3000) begin
			err_count++;
			test_done();
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Shared tasks
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		checks_done++;
		if (got !== exp) begin
			err_count++;
			$display("MISMATCH %0t got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic test_done;
		$display("checks %0d errors %0d", checks_done, err_count);
		if (err_count == 0 && checks_done > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask

	// One-cycle strobes; data judged in the cycle after the read
	task automatic rd(input logic [3:0] a, input logic [7:0] e);
		@(posedge ref_clk_i);
		rd_i <= 1'b1;
		addr_i <= a;
		@(posedge ref_clk_i);
		rd_i <= 1'b0;
		#1 chk(rdata_o, e);
	endtask

	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		@(posedge ref_clk_i);
		wr_i <= 1'b1;
		addr_i <= a;
		wdata_i <= d;
		@(posedge ref_clk_i);
		wr_i <= 1'b0;
	endtask

	task automatic pulse(input logic [3:0] v);
		@(posedge ref_clk_i);
		evt <= v;
		@(posedge ref_clk_i);
		evt <= 4'h0;
	endtask

	// Bounded wait for the release pulses, then judge what they carry
	task automatic init_seen(input logic ri, input logic [2:0] sp);
		int n;
		n = 0;
		while (pce_q !== 1'b1 && n < 40) begin
			@(posedge ref_clk_i);
			#1;
			n++;
		end
		chk({pce_q, spl_q, ri_q}, {2'b11, ri});
		chk(sp_q, sp);
		chk(pc_q, 16'h0000);
		chk(srst_q, 1'b0);
	endtask

	////////////////////////////////////////////////////////////////////////
	// Scenarios
	task automatic t_por;
		repeat (6) @(posedge ref_clk_i);
		rst_i <= 1'b0;
		init_seen(1'b1, RFIC_SP_TOP);
		chk({to_q, pd_q}, 2'b00);
		chk(int_q, RFIC_INT_OFF);
		chk(tmr_q, RFIC_TMR_OFF);
		chk(dir_q, RFIC_PORT_IN);
		repeat (3) @(posedge ref_clk_i);
		#1 chk(wdt_q != RFIC_WDT_CLR, 1'b1);
		rd(RFIC_OFS_SRC, 8'h01);
		rd(4'hf, 8'h00);	// Unmapped reads as zero
	endtask

	task automatic t_wdt;
		pulse(4'b0001);
		init_seen(1'b1, RFIC_SP_TOP);
		rd(RFIC_OFS_FLAGS, 8'h01);
		rd(RFIC_OFS_SRC, 8'h04);
		pulse(4'b0010);
		rd(RFIC_OFS_FLAGS, 8'h02);
		chk(halt_q, 1'b1);
		pulse(4'b0100);
		#1 chk(halt_q, 1'b0);
		pulse(4'b0010);
		pulse(4'b0001);
		init_seen(1'b0, RFIC_SP_CLR);
		rd(RFIC_OFS_FLAGS, 8'h03);
		rd(RFIC_OFS_SRC, 8'h05);
	endtask

	// Low-voltage then pin reset with both flags high, so unchanged shows
	task automatic t_ext;
		pulse(4'b0100);
		@(posedge ref_clk_i);
		lv_event_i <= 1'b1;
		repeat (4) @(posedge ref_clk_i);
		chk(srst_q, 1'b1);
		lv_event_i <= 1'b0;
		init_seen(1'b1, RFIC_SP_TOP);
		rd(RFIC_OFS_FLAGS, 8'h07);
		chk(lv_q, 1'b1);
		@(posedge ref_clk_i);
		pin_rst_n_i <= 1'b0;
		repeat (4) @(posedge ref_clk_i);
		pin_rst_n_i <= 1'b1;
		init_seen(1'b1, RFIC_SP_TOP);
		rd(RFIC_OFS_FLAGS, 8'h07);
		rd(RFIC_OFS_SRC, 8'h03);
	endtask

	// Interrupt masked, enabled, cleared; flag clear paths
	task automatic t_irq;
		rd(RFIC_OFS_IRQST, 8'h07);
		chk(irq_q, 1'b0);
		wr(RFIC_OFS_IRQEN, 8'h02);
		repeat (2) @(posedge ref_clk_i);
		#1 chk(irq_q, 1'b1);
		wr(RFIC_OFS_IRQCL, 8'h02);
		repeat (2) @(posedge ref_clk_i);
		#1 chk(irq_q, 1'b0);
		rd(RFIC_OFS_IRQST, 8'h05);
		wr(RFIC_OFS_LVCLR, 8'h04);
		wr(RFIC_OFS_FLAGS, 8'h00);
		rd(RFIC_OFS_FLAGS, 8'h03);
		chk(lv_q, 1'b0);
		pulse(4'b1000);
		rd(RFIC_OFS_FLAGS, 8'h00);
	endtask

	////////////////////////////////////////////////////////////////////////
	// Main sequence
	initial begin
		{rst_i, lv_event_i, pin_rst_n_i, wr_i, rd_i} = 5'b10100;
		evt = 4'h0;
		addr_i = 4'h0;
		wdata_i = 8'h00;
		err_count = 0;
		checks_done = 0;
		cyc = 0;
		t_por();
		t_wdt();
		t_ext();
		t_irq();
		test_done();
	end
endmodule
